// *** src/wms_pkg.sv ***
// Shared constants and types for the watchdog, mailbox and status block.
// Assumes a single 100 MHz clock and byte-wide I/O accesses.
package wms_pkg;

    // Byte offsets inside the I/O window
    localparam logic [4:0] OFS_RELOAD = 5'h00;
    localparam logic [4:0] OFS_INIT   = 5'h01;
    localparam logic [4:0] OFS_OSMB   = 5'h02;
    localparam logic [4:0] OFS_HMB    = 5'h03;
    localparam logic [4:0] OFS_STS_LO = 5'h04;
    localparam logic [4:0] OFS_STS_HI = 5'h05;

    // Widths
    localparam int CNT_W = 6;
    localparam int STS_W = 16;
    localparam int PRE_W = 26;

    // Reset values, count constants and the minimum initial value
    localparam logic [7:0]       INIT_RST   = 8'h04;
    localparam logic [7:0]       BYTE_RST   = 8'h00;
    localparam logic [CNT_W-1:0] CNT_RST    = 6'h00;
    localparam logic [CNT_W-1:0] CNT_ONE    = 6'h01;
    localparam logic [CNT_W-1:0] INIT_MIN   = 6'h04;
    localparam logic [1:0]       RSVD_BITS  = 2'h0;

    // Status bit positions
    localparam int STS_OSMB = 1;
    localparam int STS_HMB  = 2;
    localparam int STS_TMO  = 3;
    localparam int STS_SCI  = 9;
    localparam int STS_SMI  = 10;
    localparam int STS_NMI  = 11;
    localparam int STS_SERR = 12;
    localparam logic [STS_W-1:0] STS_W1C_MASK = 16'h1E0E;

    // Tick period: 0.6 s in milliseconds, clock in kHz
    localparam int TICK_MS      = 600;
    localparam int CLK_KHZ      = 100000;
    localparam int TICK_CYCLES  = TICK_MS * CLK_KHZ;

    // Destination of the handler-mailbox interrupt
    typedef enum logic [1:0] {
        SEL_LEGACY = 2'b00,
        SEL_CFG    = 2'b01,
        SEL_MGMT   = 2'b10,
        SEL_NONE   = 2'b11
    } wms_irq_sel_e;

    // Messages arriving from the memory controller hub
    typedef struct packed {
        logic serr;
        logic nmi;
        logic smi;
        logic config_event_interrupt;
    } wms_hub_msg_s;

    // Interrupt requests, one-cycle pulses
    typedef struct packed {
        logic legacy;
        logic cfgEvent;
        logic mgmt;
        logic nmi;
    } wms_irq_s;

endpackage : wms_pkg

// *** src/wms_sticky_flags.sv ***
// Bank of sticky flags, set by hardware, cleared by writing one.
// Assumes set and clear vectors are single-cycle on clk_sys.
`timescale 1ns/100ps
module wms_sticky_flags #(
    parameter int N = wms_pkg::STS_W
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    // Events and clears
    input  wire logic [N-1:0] setVec,
    input  wire logic [N-1:0] clrVec,
    // Flag state
    output logic      [N-1:0] flags
);
    logic [N-1:0] flag_r;

    // Set beats clear so an event in the clearing cycle survives
    for (genvar i = 0; i < N; i++) begin : g_flag
        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                flag_r[i] <= 1'b0;
            end else if (setVec[i]) begin
                flag_r[i] <= 1'b1;
            end else if (clrVec[i]) begin
                flag_r[i] <= 1'b0;
            end
        end
    end

    assign flags = flag_r;

endmodule : wms_sticky_flags

// *** src/wms_tick_count.sv ***
// Prescaler and six-bit watchdog countdown.
// Assumes reload is a one-cycle pulse on clk_sys.
`timescale 1ns/100ps
module wms_tick_count #(
    parameter int unsigned TICK_CYCLES = wms_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     nrst,
    // Restart request
    input  wire logic                     reload,
    input  wire logic [wms_pkg::CNT_W-1:0] loadVal,
    // Timer state
    output logic      [wms_pkg::CNT_W-1:0] count,
    output logic                          timeout
);
    localparam logic [wms_pkg::PRE_W-1:0] PRE_LAST =
        wms_pkg::PRE_W'(TICK_CYCLES - 1);
    localparam logic [wms_pkg::PRE_W-1:0] PRE_ZERO = '0;

    logic [wms_pkg::PRE_W-1:0] pre_r;
    logic [wms_pkg::CNT_W-1:0] cnt_r;
    logic                      tmo_r;
    wire                       tick = (pre_r == PRE_LAST);
    wire                       running = (cnt_r != wms_pkg::CNT_RST);

    // Prescaler restarts on reload so the first tick is a full period
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pre_r <= PRE_ZERO;
        end else if (reload || tick) begin
            pre_r <= PRE_ZERO;
        end else begin
            pre_r <= pre_r + 1'b1;
        end
    end

    // Countdown; idle at zero until the next reload
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= wms_pkg::CNT_RST;
            tmo_r <= 1'b0;
        end else begin
            tmo_r <= 1'b0;
            if (reload) begin
                cnt_r <= loadVal;
            end else if (tick && running) begin
                cnt_r <= cnt_r - 1'b1;
                tmo_r <= (cnt_r == wms_pkg::CNT_ONE);
            end
        end
    end

    assign count   = cnt_r;
    assign timeout = tmo_r;

    chk_tick_decrement: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (tick && running && !reload) |=> (cnt_r == $past(cnt_r) - 1'b1))
        else $error("countdown did not step down on tick");

endmodule : wms_tick_count

// *** src/wms_watchdog_mailbox.sv ***
// Watchdog timer, two mailboxes and event status behind a byte I/O window.
// Assumes host strobes and hub messages are synchronous to clk_sys.
//
// Operation
// - Reading the reload register returns the present countdown value.
// - Any write to the reload register restarts the countdown.
// - Top two bits of the reload read value are always zero.
// - Reload copies the six-bit initial value into the timer; bits 7:6 reserved.
// - Initial values 0 to 3 are forbidden and ignored when written.
// - Countdown advances once per tick of about 0.6 seconds.
// - Timeout sets status bit 3 and raises a management interrupt.
// - OS mailbox write stores data, raises management interrupt, sets flag.
// - OS mailbox flag is status bit 1, cleared by writing one.
// - Handler mailbox write stores data and sets the handler flag.
// - Handler mailbox write raises an interrupt at the selected destination.
// - Handler mailbox flag is status bit 2, cleared by writing one.
// - Hub system-error message sets status bit 12.
// - Hub error flag with enable sets signalled error and raises NMI or SMI.
// - Hub NMI message sets status bit 11.
// - Hub management-interrupt message sets status bit 10.
// - Hub config-event message sets status bit 9.
// - Hub flags clear only on a written one; zero leaves them.
`timescale 1ns/100ps
module wms_watchdog_mailbox #(
    parameter int unsigned TICK_CYCLES = wms_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 nrst,
    // Host I/O window
    input  wire logic [4:0]           ioAddr,
    input  wire logic [7:0]           ioWrData,
    input  wire logic                 ioWr,
    input  wire logic                 ioRd,
    output logic      [7:0]           ioRdData,
    // Hub messages, one-cycle pulses
    input  wire wms_pkg::wms_hub_msg_s hubMsg,
    // Controls held in neighbouring registers
    input  wire logic                 syserrEnable,
    input  wire logic                 nmiToMgmt,
    input  wire logic [1:0]           interruptSelectField,
    input  wire logic                 signalledSyserrClr,
    // Interrupt requests and status
    output wms_pkg::wms_irq_s         irqOut,
    output logic                      signalledSyserr,
    output logic [wms_pkg::CNT_W-1:0] watchdogCount
);

    // Register storage
    logic [7:0]               watchdogInitialReg_r;
    logic [7:0]               osMailboxReg_r;
    logic [7:0]               handlerMailboxReg_r;
    logic [7:0]               rdData_r;
    logic                     sse_r;
    logic                     sseCondD_r;
    wms_pkg::wms_irq_s        irq_r;
    wms_pkg::wms_irq_s        irq_nxt;

    // Sub-block outputs
    logic [wms_pkg::CNT_W-1:0] count;
    logic                      timeout;
    logic [wms_pkg::STS_W-1:0] watchdogStatusReg;

    // Address decode for writes
    wire wrReload = ioWr && (ioAddr == wms_pkg::OFS_RELOAD);
    wire wrInit   = ioWr && (ioAddr == wms_pkg::OFS_INIT);
    wire wrOsMb   = ioWr && (ioAddr == wms_pkg::OFS_OSMB);
    wire wrHMb    = ioWr && (ioAddr == wms_pkg::OFS_HMB);
    wire wrStsLo  = ioWr && (ioAddr == wms_pkg::OFS_STS_LO);
    wire wrStsHi  = ioWr && (ioAddr == wms_pkg::OFS_STS_HI);

    // Initial values below the minimum are dropped, old value kept
    wire initLegal = (ioWrData[wms_pkg::CNT_W-1:0] >= wms_pkg::INIT_MIN);

    // Reload always uses the stored six-bit field, not the written data
    wire [wms_pkg::CNT_W-1:0] loadVal =
        watchdogInitialReg_r[wms_pkg::CNT_W-1:0];

    // Countdown with its own prescaler
    wms_tick_count #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .reload  (wrReload),
        .loadVal (loadVal),
        .count   (count),
        .timeout (timeout)
    );

    // Events that set status flags
    logic [wms_pkg::STS_W-1:0] setVec;
    logic [wms_pkg::STS_W-1:0] clrVec;
    always_comb begin
        setVec = '0;
        setVec[wms_pkg::STS_OSMB] = wrOsMb;
        setVec[wms_pkg::STS_HMB]  = wrHMb;
        setVec[wms_pkg::STS_TMO]  = timeout;
        setVec[wms_pkg::STS_SCI]  = hubMsg.config_event_interrupt;
        setVec[wms_pkg::STS_SMI]  = hubMsg.smi;
        setVec[wms_pkg::STS_NMI]  = hubMsg.nmi;
        setVec[wms_pkg::STS_SERR] = hubMsg.serr;
    end

    // Write-one-to-clear per byte lane; only implemented bits clear
    assign clrVec = {(wrStsHi ? ioWrData : wms_pkg::BYTE_RST),
                     (wrStsLo ? ioWrData : wms_pkg::BYTE_RST)}
                    & wms_pkg::STS_W1C_MASK;

    wms_sticky_flags #(
        .N (wms_pkg::STS_W)
    ) u_flags (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .setVec  (setVec),
        .clrVec  (clrVec),
        .flags   (watchdogStatusReg)
    );

    // Signalled system error is set from the hub error flag while enabled
    wire sseCond = watchdogStatusReg[wms_pkg::STS_SERR] && syserrEnable;
    wire sseRise = sseCond && !sseCondD_r;

    // Handler mailbox destination
    wire wms_pkg::wms_irq_sel_e hSel = wms_pkg::wms_irq_sel_e'(interruptSelectField);

    // Interrupt request assembly; the error fires once per rising condition
    always_comb begin
        irq_nxt          = '0;
        irq_nxt.mgmt     = timeout
                         || wrOsMb
                         || (wrHMb && (hSel == wms_pkg::SEL_MGMT))
                         || (sseRise && nmiToMgmt);
        irq_nxt.legacy   = wrHMb && (hSel == wms_pkg::SEL_LEGACY);
        irq_nxt.cfgEvent = wrHMb && (hSel == wms_pkg::SEL_CFG);
        irq_nxt.nmi      = sseRise && !nmiToMgmt;
    end

    // Read data mux; unmapped offsets read zero
    wire [7:0] rdStsLo = watchdogStatusReg[7:0];
    wire [7:0] rdStsHi = watchdogStatusReg[15:8];
    wire [7:0] rdReload = {wms_pkg::RSVD_BITS, count};
    logic [7:0] rdMux;
    always_comb begin
        if (ioAddr == wms_pkg::OFS_RELOAD) begin
            rdMux = rdReload;
        end else if (ioAddr == wms_pkg::OFS_INIT) begin
            rdMux = watchdogInitialReg_r;
        end else if (ioAddr == wms_pkg::OFS_OSMB) begin
            rdMux = osMailboxReg_r;
        end else if (ioAddr == wms_pkg::OFS_HMB) begin
            rdMux = handlerMailboxReg_r;
        end else if (ioAddr == wms_pkg::OFS_STS_LO) begin
            rdMux = rdStsLo;
        end else if (ioAddr == wms_pkg::OFS_STS_HI) begin
            rdMux = rdStsHi;
        end else begin
            rdMux = wms_pkg::BYTE_RST;
        end
    end

    // Initial-value register; illegal values never land
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            watchdogInitialReg_r <= wms_pkg::INIT_RST;
        end else if (wrInit && initLegal) begin
            watchdogInitialReg_r <= ioWrData;
        end
    end

    // Mailbox bytes; a write is both data and a doorbell
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            osMailboxReg_r      <= wms_pkg::BYTE_RST;
            handlerMailboxReg_r <= wms_pkg::BYTE_RST;
        end else begin
            if (wrOsMb) begin
                osMailboxReg_r <= ioWrData;
            end
            if (wrHMb) begin
                handlerMailboxReg_r <= ioWrData;
            end
        end
    end

    // Signalled error is sticky; a held or new condition beats the clear
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sse_r      <= 1'b0;
            sseCondD_r <= 1'b0;
        end else begin
            sseCondD_r <= sseCond;
            if (sseCond) begin
                sse_r <= 1'b1;
            end else if (signalledSyserrClr) begin
                sse_r <= 1'b0;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irq_r    <= '0;
            rdData_r <= wms_pkg::BYTE_RST;
        end else begin
            irq_r <= irq_nxt;
            if (ioRd) begin
                rdData_r <= rdMux;
            end
        end
    end

    assign ioRdData        = rdData_r;
    assign irqOut          = irq_r;
    assign signalledSyserr = sse_r;
    assign watchdogCount   = count;

    // Reads of the reload offset show the live count with zero top bits
    chk_reload_read_count: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ioRd && ioAddr == wms_pkg::OFS_RELOAD)
        |=> (ioRdData == {wms_pkg::RSVD_BITS, $past(count)}))
        else $error("reload read does not show count");

    chk_reload_top_zero: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ioRd && ioAddr == wms_pkg::OFS_RELOAD) |=> (ioRdData[7:6] == 2'b00))
        else $error("reload read top bits not zero");

    chk_reload_restart: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        wrReload |=> (count == $past(loadVal)))
        else $error("reload did not restart countdown");

    chk_init_ignored: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (wrInit && !initLegal)
        |=> $stable(watchdogInitialReg_r))
        else $error("illegal initial value stored");

    chk_timeout_status: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        timeout |=> (watchdogStatusReg[wms_pkg::STS_TMO] && irqOut.mgmt))
        else $error("timeout flag or interrupt missing");

    chk_osmb_doorbell: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        wrOsMb |=> (osMailboxReg_r == $past(ioWrData)
                    && watchdogStatusReg[wms_pkg::STS_OSMB] && irqOut.mgmt))
        else $error("OS mailbox write effects missing");

    chk_hmb_route: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (wrHMb && hSel == wms_pkg::SEL_LEGACY) |=> (irqOut.legacy && !irqOut.mgmt))
        else $error("handler mailbox interrupt misrouted");

    chk_hub_serr_set: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        hubMsg.serr |=> watchdogStatusReg[wms_pkg::STS_SERR])
        else $error("hub error message not flagged");

    chk_w1c_zero_keep: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (wrStsHi && !ioWrData[3] && watchdogStatusReg[wms_pkg::STS_NMI])
        |=> watchdogStatusReg[wms_pkg::STS_NMI])
        else $error("flag cleared by a written zero");

    chk_sse_raise: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (sseCond && !sseCondD_r && !nmiToMgmt) |=> (signalledSyserr && irqOut.nmi))
        else $error("signalled error or NMI missing");

    // Timer restart, load and stepping
    chk_reload_no_timeout: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        wrReload |=> !timeout)
        else $error("timeout despite reload");

    chk_reload_init_field: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        wrReload
        |=> (watchdogCount == $past(watchdogInitialReg_r[wms_pkg::CNT_W-1:0])))
        else $error("reload did not load initial field");

    chk_count_step_one: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        !wrReload
        |=> (count == $past(count) || count == $past(count) - 1'b1))
        else $error("count moved by more than one");

    chk_timeout_at_zero: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        timeout |-> (count == wms_pkg::CNT_RST))
        else $error("timeout with nonzero count");

    // Mailbox data, flags and config routing
    chk_osmb_flag_clear: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (wrStsLo && ioWrData[wms_pkg::STS_OSMB])
        |=> !watchdogStatusReg[wms_pkg::STS_OSMB])
        else $error("OS mailbox flag not cleared");

    chk_hmb_store: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        wrHMb
        |=> (handlerMailboxReg_r == $past(ioWrData) && watchdogStatusReg[wms_pkg::STS_HMB]))
        else $error("handler mailbox write effects missing");

    chk_hmb_cfg_route: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (wrHMb && hSel == wms_pkg::SEL_CFG)
        |=> (irqOut.cfgEvent && !irqOut.legacy))
        else $error("handler mailbox config route missing");

    chk_hmb_flag_clear: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (wrStsLo && ioWrData[wms_pkg::STS_HMB])
        |=> !watchdogStatusReg[wms_pkg::STS_HMB])
        else $error("handler mailbox flag not cleared");

    // Hub message flags and error routing
    chk_hub_nmi_set: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        hubMsg.nmi |=> watchdogStatusReg[wms_pkg::STS_NMI])
        else $error("hub NMI message not flagged");

    chk_hub_mgmt_set: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        hubMsg.smi |=> watchdogStatusReg[wms_pkg::STS_SMI])
        else $error("hub management message not flagged");

    chk_hub_cfg_set: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        hubMsg.config_event_interrupt |=> watchdogStatusReg[wms_pkg::STS_SCI])
        else $error("hub config message not flagged");

    chk_sse_reroute: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (sseRise && nmiToMgmt)
        |=> (signalledSyserr && irqOut.mgmt && !irqOut.nmi))
        else $error("rerouted error interrupt missing");

endmodule : wms_watchdog_mailbox

// *** test/tb_wms_watchdog_mailbox.sv ***
// Self-checking bench for the watchdog, mailbox and status block.
// Assumes a short tick of 8 cycles and the hub model on the message port.
`timescale 1ns/100ps
module tb_wms_watchdog_mailbox;
    localparam int TICK = 8;
    logic                  clk_sys = 1'b0;
    logic                  nrst = 1'b0;
    logic [4:0]            ioAddr = 5'h00;
    logic [7:0]            ioWrData = 8'h00;
    logic                  ioWr = 1'b0;
    logic                  ioRd = 1'b0;
    logic [7:0]            ioRdData;
    wms_pkg::wms_hub_msg_s hubMsg;
    wms_pkg::wms_hub_msg_s hubCause;
    wms_pkg::wms_hub_msg_s sendMsg = '0;
    logic                  sendStb = 1'b0;
    logic                  syserrEnable = 1'b0;
    logic                  nmiToMgmt = 1'b0;
    logic [1:0]            interruptSelectField = 2'h3;
    logic                  signalledSyserrClr = 1'b0;
    wms_pkg::wms_irq_s     irqOut;
    logic                  signalledSyserr;
    logic [5:0]            watchdogCount;
    logic [3:0]            irqVec;
    int                    irqCnt [4] = '{0, 0, 0, 0};
    int                    base [4];
    int                    err_count = 0;
    int                    total_checks = 0;
    int                    cyc;

    wms_watchdog_mailbox #(.TICK_CYCLES(TICK)) i_wms_watchdog_mailbox (
        .clk_sys(clk_sys), .nrst(nrst), .ioAddr(ioAddr), .ioWrData(ioWrData),
        .ioWr(ioWr), .ioRd(ioRd), .ioRdData(ioRdData), .hubMsg(hubMsg),
        .syserrEnable(syserrEnable), .nmiToMgmt(nmiToMgmt),
        .interruptSelectField(interruptSelectField),
        .signalledSyserrClr(signalledSyserrClr), .irqOut(irqOut),
        .signalledSyserr(signalledSyserr), .watchdogCount(watchdogCount));

    wms_hub_model i_wms_hub_model (
        .clk_sys(clk_sys), .nrst(nrst), .sendMsg(sendMsg), .sendStb(sendStb),
        .hubMsg(hubMsg), .lastCause(hubCause));

    always #5 clk_sys = ~clk_sys;

    // Pulse counters; interrupts are single-cycle so counting edges suffices
    assign irqVec = irqOut;
    always @(posedge clk_sys) begin
        for (int k = 0; k < 4; k++) begin
            if (irqVec[k] === 1'b1) irqCnt[k]++;
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict

    task automatic checkByte(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : checkByte

    task automatic checkCount(input string n, input int e, input int g);
        total_checks++;
        if (g != e) begin
            err_count++;
            $display("[FAIL] %s expected %0d seen %0d", n, e, g);
        end
    endtask : checkCount

    task automatic ioWrite(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        ioAddr <= a;
        ioWrData <= d;
        ioWr <= 1'b1;
        @(posedge clk_sys);
        ioWr <= 1'b0;
    endtask : ioWrite

    // Snapshot of the count taken while the read strobe is held
    task automatic ioRead(input logic [4:0] a, output logic [7:0] d, output logic [5:0] s);
        @(posedge clk_sys);
        ioAddr <= a;
        ioRd <= 1'b1;
        #1 s = watchdogCount;
        @(posedge clk_sys);
        ioRd <= 1'b0;
        @(posedge clk_sys);
        #1 d = ioRdData;
    endtask : ioRead

    task automatic rdCheck(input string n, input logic [4:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic [5:0] s;
        ioRead(a, d, s);
        checkByte(n, e, d);
    endtask : rdCheck

    task automatic waitCount(input logic [5:0] t, input int lim, output int c);
        c = 0;
        while (watchdogCount !== t) begin
            @(posedge clk_sys);
            #1 c++;
            if (c > lim) begin
                err_count++;
                $display("[FAIL] count wait expected %h seen %h", t, watchdogCount);
                print_verdict();
            end
        end
    endtask : waitCount

    task automatic sendHub(input logic [3:0] m);
        @(posedge clk_sys);
        sendMsg <= m;
        sendStb <= 1'b1;
        @(posedge clk_sys);
        sendStb <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask : sendHub

    task automatic snapIrq();
        foreach (base[k]) base[k] = irqCnt[k];
    endtask : snapIrq

    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        $display("[FAIL] run time expected finish seen hang");
        print_verdict();
    end

    initial begin
        logic [7:0] d;
        logic [5:0] s;
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        // Reset values, unmapped offset reads zero
        rdCheck("reload rst", 5'h00, 8'h00);
        rdCheck("init rst", 5'h01, 8'h04);
        rdCheck("osmb rst", 5'h02, 8'h00);
        rdCheck("hmb rst", 5'h03, 8'h00);
        rdCheck("sts lo rst", 5'h04, 8'h00);
        rdCheck("sts hi rst", 5'h05, 8'h00);
        rdCheck("unmapped", 5'h06, 8'h00);
        // Initial value: forbidden values keep the previous one
        ioWrite(5'h01, 8'h03);
        rdCheck("init 03", 5'h01, 8'h04);
        ioWrite(5'h01, 8'h3F);
        rdCheck("init 3F", 5'h01, 8'h3F);
        ioWrite(5'h01, 8'h00);
        rdCheck("init 00", 5'h01, 8'h3F);
        ioWrite(5'h01, 8'h05);
        rdCheck("init 05", 5'h01, 8'h05);
        // Countdown: load, tick period, restart, timeout
        ioWrite(5'h00, 8'hFF);
        waitCount(6'h05, 10, cyc);
        waitCount(6'h04, 20, cyc);
        waitCount(6'h03, 20, cyc);
        checkCount("tick period", TICK, cyc);
        ioRead(5'h00, d, s);
        checkByte("reload read", 8'h03, d);
        checkByte("count out", 8'h03, {2'b00, s});
        ioWrite(5'h00, 8'h00);
        waitCount(6'h05, 10, cyc);
        snapIrq();
        // One cycle of the run is spent seeing the reloaded value
        waitCount(6'h00, 100, cyc);
        checkCount("timeout cycles", 5 * TICK - 1, cyc);
        repeat (3) @(posedge clk_sys);
        checkCount("timeout mgmt", base[1] + 1, irqCnt[1]);
        rdCheck("timeout flag", 5'h04, 8'h08);
        repeat (20) @(posedge clk_sys);
        rdCheck("count held", 5'h00, 8'h00);
        ioWrite(5'h04, 8'h08);
        rdCheck("timeout clr", 5'h04, 8'h00);
        // OS mailbox
        snapIrq();
        ioWrite(5'h02, 8'hA5);
        repeat (3) @(posedge clk_sys);
        checkCount("osmb mgmt", base[1] + 1, irqCnt[1]);
        rdCheck("osmb data", 5'h02, 8'hA5);
        ioWrite(5'h04, 8'h00);
        rdCheck("osmb flag", 5'h04, 8'h02);
        ioWrite(5'h04, 8'h02);
        rdCheck("osmb clr", 5'h04, 8'h00);
        // Handler mailbox for every destination code
        for (int sel = 0; sel < 4; sel++) begin
            @(posedge clk_sys);
            interruptSelectField <= sel[1:0];
            snapIrq();
            ioWrite(5'h03, 8'h30 + sel[7:0]);
            repeat (3) @(posedge clk_sys);
            for (int k = 0; k < 4; k++) begin
                checkCount("hmb irq", base[k] + int'(k == 3 - sel && sel != 3), irqCnt[k]);
            end
            rdCheck("hmb data", 5'h03, 8'h30 + sel[7:0]);
            rdCheck("hmb flag", 5'h04, 8'h04);
            ioWrite(5'h04, 8'h04);
            rdCheck("hmb clr", 5'h04, 8'h00);
        end
        // Hub messages, one at a time, sticky until a written one
        for (int k = 0; k < 4; k++) begin
            sendHub(4'h1 << k);
            rdCheck("hub set", 5'h05, 8'h02 << k);
            checkByte("hub cause", 8'h01 << k, {4'h0, hubCause});
            ioWrite(5'h05, 8'h00);
            rdCheck("hub keep", 5'h05, 8'h02 << k);
            ioWrite(5'h05, 8'hFF);
            rdCheck("hub clr", 5'h05, 8'h00);
        end
        // Hub error with enable: NMI, then rerouted to management
        for (int r = 0; r < 2; r++) begin
            @(posedge clk_sys);
            syserrEnable <= 1'b1;
            nmiToMgmt <= r[0];
            snapIrq();
            sendHub(4'h8);
            checkCount("serr nmi", base[0] + 1 - r, irqCnt[0]);
            checkCount("serr mgmt", base[1] + r, irqCnt[1]);
            checkByte("serr sig", 8'h01, {7'h00, signalledSyserr});
            ioWrite(5'h05, 8'h10);
            signalledSyserrClr <= 1'b1;
            @(posedge clk_sys);
            signalledSyserrClr <= 1'b0;
            repeat (2) @(posedge clk_sys);
            checkByte("serr sig clr", 8'h00, {7'h00, signalledSyserr});
        end
        print_verdict();
    end
endmodule : tb_wms_watchdog_mailbox

// *** test/wms_hub_model.sv ***
// Behavioural hub controller that sends message pulses to the status block.
// Assumes the bench raises sendStb for one cycle per message.
`timescale 1ns/100ps
module wms_hub_model (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    // Bench command
    input  wire wms_pkg::wms_hub_msg_s sendMsg,
    input  wire logic                  sendStb,
    // Message pulses to the device
    output wms_pkg::wms_hub_msg_s      hubMsg,
    // Last message, read back by software as the cause
    output wms_pkg::wms_hub_msg_s      lastCause
);
    // One-cycle pulses, idle low so a stale message never repeats
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hubMsg <= '0;
        end else begin
            hubMsg <= sendStb ? sendMsg : '0;
        end
    end

    // Cause record that software queries after seeing a flag
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            lastCause <= '0;
        end else if (sendStb) begin
            lastCause <= sendMsg;
        end
    end
endmodule : wms_hub_model
